// ===== hdl/pth_pkg.sv
package pth_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_RSTSEL = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

  // control register fields
  localparam int CTL_ON_BIT = 7;
  localparam int CTL_CKPS_LSB = 4;
  localparam int CTL_OUTPS_LSB = 0;

  // widths
  localparam int COUNT_W = 8;
  localparam int CKPS_W = 3;
  localparam int OUTPS_W = 4;
  localparam int MODE_W = 5;
  localparam int RSTSEL_W = 4;
  localparam int PRE_W = 7;

  // reset values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;

  typedef enum logic [4:0] {
    MODE_SW_GATE = 5'b00000,
    MODE_GATE_HI = 5'b00001,
    MODE_GATE_LO = 5'b00010,
    MODE_LIM_BOTH = 5'b00011,
    MODE_LIM_RISE = 5'b00100,
    MODE_LIM_FALL = 5'b00101,
    MODE_LIM_LOW = 5'b00110,
    MODE_LIM_HIGH = 5'b00111,
    MODE_OS_SW = 5'b01000,
    MODE_OS_RISE = 5'b01001,
    MODE_OS_FALL = 5'b01010,
    MODE_OS_BOTH = 5'b01011,
    MODE_OSL_RISE = 5'b01100,
    MODE_OSL_FALL = 5'b01101,
    MODE_OSV_HIGH = 5'b01110,
    MODE_OSV_LOW = 5'b01111
  } pth_mode_type;

endpackage : pth_pkg

// ===== hdl/pth_timer.sv
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module pth_timer
  import pth_pkg::*;
#(
  parameter int EXT_SRC_COUNT = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // external reset sources, asynchronous
  input wire logic [EXT_SRC_COUNT-1:0] extResetIn,
  // outputs to other peripherals
  output logic postscaledPulse,
  output logic [COUNT_W-1:0] timerCount,
  output logic [COUNT_W-1:0] periodValue,
  output logic periodMatch,
  output logic timerIrq
);

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] period;
    logic on;
    logic [CKPS_W-1:0] ckps;
    logic [OUTPS_W-1:0] outps;
    logic [MODE_W-1:0] mode;
    logic [RSTSEL_W-1:0] rstsel;
    logic flag;
    logic irqEn;
    logic [PRE_W-1:0] preCnt;
    logic [OUTPS_W-1:0] postCnt;
    logic pulse;
    logic matchPulse;
    logic started;
    logic ersSync1;
    logic ersSync2;
    logic ersPrev;
    logic dpWrite;
    logic dpRead;
    logic [7:0] dpAddr;
    logic rdWait;
    logic [31:0] rdata;
  } pth_state_type;

  pth_state_type s;
  pth_state_type next_s;

  function automatic logic [PRE_W-1:0] preLimit(input logic [CKPS_W-1:0] sel);
    preLimit = PRE_W'((8'h01 << sel) - 8'h01);
  endfunction : preLimit

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == OFS_COUNT) || (a == OFS_PERIOD) || (a == OFS_CONTROL)
      || (a == OFS_LIMIT) || (a == OFS_RSTSEL) || (a == OFS_IRQ_STATUS)
      || (a == OFS_IRQ_ENABLE);
  endfunction : isMapped

  logic selRaw;
  logic ers;
  logic rise;
  logic fall;
  logic tick;
  logic run;
  logic hwReset;
  logic startEvt;
  logic matchEvt;
  logic postMatch;
  logic addrTaken;
  logic cntWr;
  logic ctlWr;

  ////////////////////////////////////////////////////////////////////////////
  // source select and edge detect
  assign selRaw = (32'(s.rstsel) < EXT_SRC_COUNT) ? extResetIn[s.rstsel] : 1'b0;
  assign ers = s.ersSync2;
  assign rise = ers && !s.ersPrev;
  assign fall = !ers && s.ersPrev;
  assign tick = (s.preCnt == preLimit(s.ckps));

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  always_comb begin
    run = 1'b0;
    hwReset = 1'b0;
    startEvt = 1'b0;
    case (pth_mode_type'(s.mode))
      MODE_SW_GATE: begin
        run = s.on;
      end
      MODE_GATE_HI: begin
        run = s.on && !ers;
      end
      MODE_GATE_LO: begin
        run = s.on && ers;
      end
      MODE_LIM_BOTH: begin
        run = s.on;
        hwReset = s.on && (rise || fall);
      end
      MODE_LIM_RISE: begin
        run = s.on;
        hwReset = s.on && rise;
      end
      MODE_LIM_FALL: begin
        run = s.on;
        hwReset = s.on && fall;
      end
      MODE_LIM_LOW: begin
        run = s.on;
        hwReset = s.on && !ers;
      end
      MODE_LIM_HIGH: begin
        run = s.on;
        hwReset = s.on && ers;
      end
      MODE_OS_SW: begin
        run = s.on;
      end
      MODE_OS_RISE: begin
        startEvt = s.on && rise;
        run = s.on && s.started;
      end
      MODE_OS_FALL: begin
        startEvt = s.on && fall;
        run = s.on && s.started;
      end
      MODE_OS_BOTH: begin
        startEvt = s.on && (rise || fall);
        run = s.on && s.started;
      end
      MODE_OSL_RISE: begin
        startEvt = s.on && !s.started && rise;
        hwReset = s.on && s.started && rise;
        run = s.on && s.started;
      end
      MODE_OSL_FALL: begin
        startEvt = s.on && !s.started && fall;
        hwReset = s.on && s.started && fall;
        run = s.on && s.started;
      end
      MODE_OSV_HIGH: begin
        startEvt = s.on && !s.started && fall;
        hwReset = s.on && s.started && ers;
        run = s.on && s.started;
      end
      MODE_OSV_LOW: begin
        startEvt = s.on && !s.started && rise;
        hwReset = s.on && s.started && !ers;
        run = s.on && s.started;
      end
      default: begin
        run = 1'b0;
      end
    endcase
  end

  assign matchEvt = tick && run && !hwReset && (s.count == s.period);
  assign postMatch = matchEvt && (s.postCnt == s.outps);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign addrTaken = hsel && hready && htrans[1];
  assign cntWr = s.dpWrite && (s.dpAddr == OFS_COUNT);
  assign ctlWr = s.dpWrite && (s.dpAddr == OFS_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s = s;
    next_s.ersSync1 = selRaw;
    next_s.ersSync2 = s.ersSync1;
    next_s.ersPrev = s.ersSync2;
    next_s.pulse = 1'b0;
    next_s.matchPulse = matchEvt;

    // timer
    next_s.preCnt = tick ? '0 : PRE_W'(s.preCnt + 7'h01);
    if (!s.on) begin
      next_s.started = 1'b0;
    end else if (startEvt) begin
      next_s.started = 1'b1;
    end
    if (hwReset) begin
      next_s.count = COUNT_RESET;
      next_s.preCnt = '0;
      next_s.postCnt = '0;
    end else if (matchEvt) begin
      next_s.count = COUNT_RESET;
      if (postMatch) begin
        next_s.postCnt = '0;
        next_s.pulse = 1'b1;
      end else begin
        next_s.postCnt = OUTPS_W'(s.postCnt + 4'h1);
      end
      if (s.mode[3]) begin
        next_s.on = 1'b0;
        next_s.started = 1'b0;
      end
    end else if (tick && run) begin
      next_s.count = COUNT_W'(s.count + 8'h01);
    end

    // bus data phase
    next_s.dpWrite = 1'b0;
    next_s.dpRead = 1'b0;
    if (s.dpWrite) begin
      case (s.dpAddr)
        OFS_COUNT: begin
          next_s.count = hwdata[COUNT_W-1:0];
          next_s.preCnt = '0;
          next_s.postCnt = '0;
        end
        OFS_PERIOD: begin
          next_s.period = hwdata[COUNT_W-1:0];
        end
        OFS_CONTROL: begin
          next_s.on = hwdata[CTL_ON_BIT];
          next_s.ckps = hwdata[CTL_CKPS_LSB +: CKPS_W];
          next_s.outps = hwdata[CTL_OUTPS_LSB +: OUTPS_W];
          next_s.preCnt = '0;
          next_s.postCnt = '0;
        end
        OFS_LIMIT: begin
          next_s.mode = hwdata[MODE_W-1:0];
        end
        OFS_RSTSEL: begin
          next_s.rstsel = hwdata[RSTSEL_W-1:0];
        end
        OFS_IRQ_ENABLE: begin
          next_s.irqEn = hwdata[0];
        end
        default: begin
          next_s.irqEn = s.irqEn;
        end
      endcase
    end

    // interrupt flag: write one clears, set wins
    if (s.dpWrite && (s.dpAddr == OFS_IRQ_STATUS) && hwdata[0]) begin
      next_s.flag = 1'b0;
    end
    if (postMatch && !hwReset) begin
      next_s.flag = 1'b1;
    end

    // read takes one wait state so a prior write is visible
    if (s.rdWait) begin
      next_s.rdWait = 1'b0;
      next_s.rdata = 32'h00000000;
      case (s.dpAddr)
        OFS_COUNT: next_s.rdata[COUNT_W-1:0] = s.count;
        OFS_PERIOD: next_s.rdata[COUNT_W-1:0] = s.period;
        OFS_CONTROL: begin
          next_s.rdata[CTL_ON_BIT] = s.on;
          next_s.rdata[CTL_CKPS_LSB +: CKPS_W] = s.ckps;
          next_s.rdata[CTL_OUTPS_LSB +: OUTPS_W] = s.outps;
        end
        OFS_LIMIT: next_s.rdata[MODE_W-1:0] = s.mode;
        OFS_RSTSEL: next_s.rdata[RSTSEL_W-1:0] = s.rstsel;
        OFS_IRQ_STATUS: next_s.rdata[0] = s.flag;
        OFS_IRQ_ENABLE: next_s.rdata[0] = s.irqEn;
        default: next_s.rdata = 32'h00000000;
      endcase
    end

    // bus address phase
    if (addrTaken) begin
      next_s.dpAddr = isMapped(haddr[7:0]) && (haddr[31:8] == 24'h000000)
        ? haddr[7:0] : 8'hFC;
      next_s.dpWrite = hwrite;
      next_s.dpRead = !hwrite;
      next_s.rdWait = !hwrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.count <= COUNT_RESET;
      s.period <= PERIOD_RESET;
      s.dpAddr <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hrdata = s.rdata;
  assign hreadyout = !s.rdWait;
  assign hresp = 1'b0;
  assign postscaledPulse = s.pulse;
  assign timerCount = s.count;
  assign periodValue = s.period;
  assign periodMatch = s.matchPulse;
  assign timerIrq = s.flag && s.irqEn;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_MATCH_WRAP: assert property (@(posedge clk) disable iff (!resetn)
    matchEvt && !s.dpWrite |=> s.count == 8'h00)
    else $error("count did not wrap after period match");

  AST_PRE_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
    (cntWr || ctlWr) |=> (s.preCnt == 7'h00) && (s.postCnt == 4'h0))
    else $error("scalers not cleared by register write");

  AST_CTL_KEEPS_COUNT: assert property (@(posedge clk) disable iff (!resetn)
    ctlWr && !tick && !hwReset |=> s.count == $past(s.count))
    else $error("control write changed the count");

  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!resetn)
    postMatch && !hwReset |=> s.flag)
    else $error("flag not set on postscaler match");

  AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!resetn)
    timerIrq |-> s.irqEn && s.flag)
    else $error("interrupt forwarded while disabled");

  AST_PULSE: assert property (@(posedge clk) disable iff (!resetn)
    postscaledPulse == $past(postMatch && !hwReset))
    else $error("postscaled pulse does not follow match");

  AST_ONESHOT_OFF: assert property (@(posedge clk) disable iff (!resetn)
    matchEvt && s.mode[3] && !ctlWr |=> !s.on)
    else $error("one-shot did not clear on bit");

  AST_HOLD_OFF: assert property (@(posedge clk) disable iff (!resetn)
    !s.on && !s.dpWrite |=> s.count == $past(s.count))
    else $error("count changed while timer off");

  AST_LEVEL_RESET: assert property (@(posedge clk) disable iff (!resetn)
    s.on && (s.mode == MODE_LIM_HIGH) && ers && !cntWr |=> s.count == 8'h00)
    else $error("count not held in reset at active level");

  AST_PRESCALE: assert property (@(posedge clk) disable iff (!resetn)
    !s.dpWrite && !hwReset && !tick |=> s.preCnt == $past(s.preCnt) + 7'h01)
    else $error("prescaler did not advance");

  AST_ARM_NEEDS_ON: assert property (@(posedge clk) disable iff (!resetn)
    !s.on |=> !s.started)
    else $error("start latch survived on bit clear");

  AST_ARMED_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    s.on && !s.started && s.mode[3] && (s.mode[2:0] != 3'b000) && !s.dpWrite
      |=> s.count == $past(s.count))
    else $error("armed one-shot counted before its edge");

  AST_LIMIT_OS_RESET: assert property (@(posedge clk) disable iff (!resetn)
    s.on && s.started && (s.mode == MODE_OSL_RISE) && rise && !cntWr |=> s.count == 8'h00)
    else $error("limit one-shot edge did not reset count");

  AST_GATE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    s.on && (s.mode == MODE_GATE_HI) && ers && !s.dpWrite |=> s.count == $past(s.count))
    else $error("count moved while gated");

  AST_HW_CLEARS_SCALERS: assert property (@(posedge clk) disable iff (!resetn)
    hwReset |=> (s.preCnt == 7'h00) && (s.postCnt == 4'h0))
    else $error("scalers not cleared by external reset event");

endmodule : pth_timer
`default_nettype wire

// ===== tb/period_timer_hw_limit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module period_timer_hw_limit_tb_top;
  import pth_pkg::*;
  //////////////////////////////
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, a;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, postscaledPulse, periodMatch, timerIrq;
  logic level = 1'b0, slow = 1'b0;
  logic [15:0] extResetIn;
  logic [7:0] timerCount, periodValue;
  int miscompares = 0, nTests = 0;
  localparam int CFG[5][4] = '{'{0, 0, 30, 10}, '{2, 0, 36, 3}, '{0, 2, 36, 4},
    '{7, 0, 768, 2}, '{0, 15, 96, 2}};
  always #10 clk = ~clk;
  pth_timer i_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .extResetIn(extResetIn),
    .postscaledPulse(postscaledPulse), .timerCount(timerCount),
    .periodValue(periodValue), .periodMatch(periodMatch), .timerIrq(timerIrq));
  pth_ext_model i_ext (.clk(clk), .srcSel(4'h5), .level(level), .slow(slow),
    .extResetIn(extResetIn));
  //////////////////////////////
  task finishTest;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finishTest
  task check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : check
  task cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  // ready and data are taken before the edge that ends the phase
  task waitRdy(output logic [31:0] d);
    int i;
    logic r;
    i = 0;
    do begin
      @(negedge clk);
      r = hreadyout;
      d = hrdata;
      @(posedge clk);
      i++;
    end while (r !== 1'b1 && i < 20);
    if (r !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: bus ready timeout", $time);
      finishTest();
    end
  endtask : waitRdy
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    waitRdy(r);
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy(r);
    check({31'h0, hresp}, 32'h0, "response");
  endtask : bus
  task wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, ad, d, r);
  endtask : wr
  task rd(input logic [7:0] ad, output logic [31:0] r);
    bus(1'b0, ad, 32'h0, r);
  endtask : rd
  task start(input logic [4:0] md, input logic lv, input logic [31:0] per);
    level <= lv;
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_LIMIT, {27'h0, md});
    wr(OFS_PERIOD, per);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CONTROL, 32'h80);
  endtask : start
  task watch(input int n, output int p, output int m, output int w, output int mx);
    logic prev;
    p = 0;
    m = 0;
    w = 0;
    mx = 0;
    prev = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (postscaledPulse === 1'b1) p++;
      if (postscaledPulse === 1'b1 && prev) w++;
      if (periodMatch === 1'b1) m++;
      if (int'(timerCount) > mx) mx = int'(timerCount);
      prev = (postscaledPulse === 1'b1);
    end
    @(posedge clk);
  endtask : watch
  //////////////////////////////
  task testReset;
    rd(OFS_COUNT, q);
    check(q, 32'h0, "count");
    rd(OFS_PERIOD, q);
    check(q, 32'hFF, "period");
    rd(8'h40, q);
    check(q, 32'h0, "unmapped");
    wr(OFS_PERIOD, 32'h2);
    rd(OFS_PERIOD, q);
    check(q, 32'h2, "period rw");
    check({24'h0, periodValue}, 32'h2, "period out");
    $display("test reset done");
  endtask : testReset
  task testScale;
    int p, m, w, mx;
    for (int i = 0; i < 5; i++) begin
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CONTROL, 32'(128 + (CFG[i][0] << 4) + CFG[i][1]));
      cycles(3);
      watch(CFG[i][2], p, m, w, mx);
      check(32'(p), 32'(CFG[i][3]), "pulses");
      check(32'(m), 32'(CFG[i][2] / (3 << CFG[i][0])), "matches");
      check(32'(w), 32'h0, "pulse width");
      check(32'(mx), 32'h2, "peak");
    end
    $display("test scale done");
  endtask : testScale
  task testIrq;
    rd(OFS_IRQ_STATUS, q);
    check(q, 32'h1, "flag");
    check({31'h0, timerIrq}, 32'h0, "masked");
    wr(OFS_IRQ_ENABLE, 32'h1);
    @(negedge clk);
    check({31'h0, timerIrq}, 32'h1, "irq");
    @(posedge clk);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_IRQ_STATUS, 32'h1);
    rd(OFS_IRQ_STATUS, q);
    check(q, 32'h0, "flag clear");
    $display("test irq done");
  endtask : testIrq
  task testHold;
    start(MODE_SW_GATE, 1'b0, 32'hFF);
    cycles(20);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_COUNT, a);
    wr(OFS_CONTROL, 32'h35);
    cycles(5);
    rd(OFS_COUNT, q);
    check(q, a, "held");
    check({31'h0, a != 0}, 32'h1, "ran");
    $display("test hold done");
  endtask : testHold
  task testModes;
    start(MODE_OS_SW, 1'b0, 32'h3);
    cycles(20);
    rd(OFS_CONTROL, q);
    check({31'h0, q[7]}, 32'h0, "one-shot on");
    rd(OFS_COUNT, q);
    check(q, 32'h0, "one-shot count");
    start(MODE_GATE_HI, 1'b1, 32'hFF);
    cycles(10);
    rd(OFS_COUNT, q);
    check(q, 32'h0, "gated");
    level <= 1'b0;
    cycles(20);
    rd(OFS_COUNT, q);
    check({31'h0, q != 0}, 32'h1, "ungated");
    start(MODE_LIM_HIGH, 1'b1, 32'hFF);
    cycles(10);
    rd(OFS_COUNT, q);
    check(q, 32'h0, "level reset");
    level <= 1'b0;
    cycles(20);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_COUNT, a);
    level <= 1'b1;
    cycles(10);
    rd(OFS_COUNT, q);
    check(q, a, "off ignores");
    start(MODE_LIM_RISE, 1'b0, 32'hFF);
    cycles(40);
    rd(OFS_COUNT, a);
    level <= 1'b1;
    cycles(6);
    rd(OFS_COUNT, q);
    check({31'h0, q < a}, 32'h1, "edge reset");
    $display("test modes done");
  endtask : testModes
  task testEdgeOs;
    slow <= 1'b1;
    start(MODE_OS_RISE, 1'b0, 32'hFF);
    cycles(20);
    rd(OFS_COUNT, q);
    check(q, 32'h0, "armed");
    level <= 1'b1;
    cycles(10);
    rd(OFS_COUNT, q);
    check({31'h0, q != 0}, 32'h1, "started");
    cycles(300);
    rd(OFS_CONTROL, q);
    check({31'h0, q[7]}, 32'h0, "on cleared");
    slow <= 1'b0;
    $display("test edge one-shot done");
  endtask : testEdgeOs
  task testLimitOs;
    level <= 1'b0;
    cycles(6);
    start(MODE_OSL_RISE, 1'b1, 32'hFF);
    cycles(20);
    rd(OFS_COUNT, q);
    check(q, 32'h0, "edge before on");
    level <= 1'b0;
    cycles(6);
    level <= 1'b1;
    cycles(30);
    rd(OFS_COUNT, a);
    check({31'h0, a != 0}, 32'h1, "limit start");
    level <= 1'b0;
    cycles(6);
    level <= 1'b1;
    cycles(6);
    rd(OFS_COUNT, q);
    check({31'h0, q < a}, 32'h1, "limit reset");
    start(MODE_OSV_HIGH, 1'b1, 32'hFF);
    cycles(10);
    rd(OFS_COUNT, q);
    check(q, 32'h0, "level held");
    level <= 1'b0;
    cycles(20);
    rd(OFS_COUNT, a);
    check({31'h0, a != 0}, 32'h1, "level start");
    level <= 1'b1;
    cycles(6);
    rd(OFS_COUNT, q);
    check(q, 32'h0, "level reset");
    wr(OFS_CONTROL, 32'h0);
    level <= 1'b0;
    cycles(6);
    wr(OFS_CONTROL, 32'h80);
    cycles(10);
    rd(OFS_COUNT, q);
    check(q, 32'h0, "new edge needed");
    wr(OFS_CONTROL, 32'h0);
    $display("test limit one-shot done");
  endtask : testLimitOs
  initial begin
    cycles(12);
    resetn <= 1'b1;
    @(posedge clk);
    testReset();
    wr(OFS_RSTSEL, 32'h5);
    testScale();
    testIrq();
    testHold();
    testModes();
    testEdgeOs();
    testLimitOs();
    finishTest();
  end
endmodule : period_timer_hw_limit_tb_top
`default_nettype wire

// ===== tb/pth_ext_model.sv
`timescale 1ns/10ps
`default_nettype none
module pth_ext_model (
  // clock
  input wire logic clk,
  // control from bench
  input wire logic [3:0] srcSel,
  input wire logic level,
  input wire logic slow,
  // reset sources
  output logic [15:0] extResetIn
);
  logic lateLevel = 1'b0;
  logic noise = 1'b0;
  always @(posedge clk) begin
    lateLevel <= level;
    noise <= ~noise;
  end
  // unselected sources toggle every cycle
  always_comb begin
    extResetIn = {16{noise}};
    extResetIn[srcSel] = slow ? lateLevel : level;
  end
endmodule : pth_ext_model
`default_nettype wire
